// [hdl/sia_dev.sv]
// sensor end of the two-wire register port with its register space
// assumes link levels from sia_if, clk far faster than the link clock
`timescale 1ns/1ps
`include "sia_consts.svh"
module sia_dev
(
	input  wire logic        clk,
	input  wire logic        nrst,
	sia_if.dev               link,
	input  wire logic        address_select_setting,
	input  wire logic        vertical_sync_pin,
	output logic             sleep_mode,
	output logic [15:0]      lanes_active,
	output logic             update_freeze_bit,
	output logic             master_run_inhibit,
	output logic             reflect_pulse
);
	logic [3:0]              raw;
	logic [3:0]              s1;
	logic [3:0]              s2;
	logic [3:0]              s3;
	logic                    scl;
	logic                    sda;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    start_seen;
	logic                    stop_seen;
	logic                    vs_fall;
	logic [6:0]              my_addr;
	sia_pkg::sia_dev_st_t    st;
	logic [7:0]              sr;
	logic [3:0]              cnt;
	logic [1:0]              phase;
	logic                    rw;
	logic                    mack;
	logic                    inc_pend;
	logic [15:0]             idx;
	logic                    oe_n;
	logic                    out_lvl;
	logic                    wr_en;
	logic [7:0]              tx_byte;
	logic [7:0]              sleep_reg;
	logic [7:0]              lane_reg;
	logic [7:0]              freeze_reg;
	logic [7:0]              run_reg;
	logic [7:0]              mem [0:`SIA_MEM_BYTES-1];

	// flat memory index of a mapped register address
	function automatic logic [12:0] mem_ix(input logic [15:0] a);
		logic [7:0] pg;
		pg = a[15:8] - `SIA_PAGE_BASE;
		return {pg[4:0], a[7:0]};
	endfunction

	// two-flop synchronisers plus one history stage for edges
	assign raw = {vertical_sync_pin, address_select_setting, link.sda, link.scl};
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1 <= `SIA_SYNC_RST;
			s2 <= `SIA_SYNC_RST;
			s3 <= `SIA_SYNC_RST;
		end
		else
		begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// link events seen on the synchronised levels
	assign scl        = s2[0];
	assign sda        = s2[1];
	assign scl_rise   = scl & ~s3[0];
	assign scl_fall   = ~scl & s3[0];
	assign start_seen = scl & s3[0] & s3[1] & ~sda; // RL5
	assign stop_seen  = scl & s3[0] & ~s3[1] & sda;
	assign vs_fall    = ~s2[3] & s3[3];
	assign my_addr    = s2[2] ? `SIA_ADDR_SEL1 : `SIA_ADDR_SEL0; // RL2

	// a data byte of a write is complete at the falling edge after its 8th bit
	assign wr_en = (st == sia_pkg::sia_d_recv) && scl_fall && (cnt == `SIA_BYTE_BITS) && (phase == 2'h2); // RL23

	// byte returned for the current index
	always_comb
	begin
		case (idx)
			`SIA_REG_SLEEP:  tx_byte = sleep_reg;
			`SIA_REG_LANE:   tx_byte = lane_reg;
			`SIA_REG_FREEZE: tx_byte = freeze_reg;
			`SIA_REG_RUN:    tx_byte = run_reg;
			default:         tx_byte = sia_pkg::sia_in_map(idx) ? mem[mem_ix(idx)] : 8'h00; // RL17
		endcase
	end

	// protocol engine
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st       <= sia_pkg::sia_d_idle;
			sr       <= 8'h00;
			cnt      <= 4'h0;
			phase    <= 2'h0;
			rw       <= 1'b0;
			mack     <= 1'b0;
			inc_pend <= 1'b0;
			idx      <= 16'h0000;
			oe_n     <= 1'b1;
		end
		else if (start_seen)
		begin
			// index survives a repeated start; phase is cleared once the address byte matches
			st   <= sia_pkg::sia_d_addr; // RL6
			cnt  <= 4'h0;
			oe_n <= 1'b1;
		end
		else if (stop_seen)
		begin
			st   <= sia_pkg::sia_d_idle;
			oe_n <= 1'b1;
		end
		else
		begin
			case (st)
				sia_pkg::sia_d_addr, sia_pkg::sia_d_recv:
				begin
					if (scl_rise && (cnt != `SIA_BYTE_BITS))
					begin
						sr  <= {sr[6:0], sda}; // RL1
						cnt <= cnt + 4'h1;
					end
					else if (scl_fall && (cnt == `SIA_BYTE_BITS))
					begin
						if (st == sia_pkg::sia_d_addr)
						begin
							if (sr[7:1] == my_addr) // RL2
							begin
								rw       <= sr[0]; // RL3
								phase    <= 2'h0;
								inc_pend <= 1'b0;
								oe_n     <= 1'b0; // RL7
								st       <= sia_pkg::sia_d_ack;
							end
							else
								st <= sia_pkg::sia_d_idle;
						end
						else
						begin
							// high then low address byte, then data
							case (phase)
								2'h0:    idx[15:8] <= sr; // RL4 RL9
								2'h1:    idx[7:0]  <= sr; // RL9
								default: ;
							endcase
							if (phase != 2'h2)
								phase <= phase + 2'h1;
							inc_pend <= (phase == 2'h2);
							oe_n     <= 1'b0; // RL7
							st       <= sia_pkg::sia_d_ack;
						end
					end
				end
				sia_pkg::sia_d_ack:
				begin
					if (scl_fall)
					begin
						cnt <= 4'h0;
						if (inc_pend)
							idx <= idx + 16'h0001; // RL10 RL23
						inc_pend <= 1'b0;
						if (rw)
						begin
							sr   <= tx_byte; // RL11 RL12
							oe_n <= tx_byte[7];
							st   <= sia_pkg::sia_d_send;
						end
						else
						begin
							oe_n <= 1'b1;
							st   <= sia_pkg::sia_d_recv;
						end
					end
				end
				sia_pkg::sia_d_send:
				begin
					if (scl_fall)
					begin
						if (cnt == `SIA_LAST_BIT)
						begin
							oe_n <= 1'b1; // RL7
							st   <= sia_pkg::sia_d_mack;
						end
						else
						begin
							sr   <= {sr[6:0], 1'b0}; // RL1
							oe_n <= sr[6];
							cnt  <= cnt + 4'h1;
						end
					end
				end
				sia_pkg::sia_d_mack:
				begin
					if (scl_rise)
					begin
						mack <= ~sda;
						idx  <= idx + 16'h0001; // RL10 RL13
					end
					else if (scl_fall)
					begin
						cnt <= 4'h0;
						if (mack)
						begin
							sr   <= tx_byte; // RL13
							oe_n <= tx_byte[7];
							st   <= sia_pkg::sia_d_send;
						end
						else
							st <= sia_pkg::sia_d_idle;
					end
				end
				default:
					st <= sia_pkg::sia_d_idle;
			endcase
		end
	end

	// open-drain data pin only ever pulls low
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			out_lvl <= 1'b0;
		else
			out_lvl <= 1'b0;
	end
	assign link.d_sda_out  = out_lvl;
	assign link.d_sda_oe_n = oe_n;

	// frame-reflected bytes live in the paged memory
	always_ff @(posedge clk)
	begin
		if (wr_en && sia_pkg::sia_in_map(idx))
			mem[mem_ix(idx)] <= sr; // RL17 RL23
	end

	// immediate control registers, unused bits held at zero
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sleep_reg  <= `SIA_SLEEP_RST; // RL19
			lane_reg   <= `SIA_LANE_RST;
			freeze_reg <= `SIA_FREEZE_RST;
			run_reg    <= `SIA_RUN_RST; // RL22
		end
		else if (wr_en)
		begin
			case (idx)
				`SIA_REG_SLEEP:  sleep_reg  <= sr & `SIA_BIT0_MASK; // RL15 RL19
				`SIA_REG_LANE:   lane_reg   <= sr & `SIA_LANE_MASK; // RL20
				`SIA_REG_FREEZE: freeze_reg <= sr & `SIA_BIT0_MASK; // RL21
				`SIA_REG_RUN:    run_reg    <= sr & `SIA_BIT0_MASK; // RL22
				default:         ;
			endcase
		end
	end

	// control outputs and frame reflection strobe
	assign sleep_mode         = sleep_reg[0];
	assign update_freeze_bit  = freeze_reg[0];
	assign master_run_inhibit = run_reg[0];
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lanes_active  <= `SIA_MASK_16;
			reflect_pulse <= 1'b0;
		end
		else
		begin
			reflect_pulse <= vs_fall & ~freeze_reg[0]; // RL15 RL21
			case (lane_reg[7:4])
				`SIA_LANES_8: lanes_active <= `SIA_MASK_8; // RL20
				`SIA_LANES_4: lanes_active <= `SIA_MASK_4;
				default:      lanes_active <= `SIA_MASK_16;
			endcase
		end
	end
endmodule

// [hdl/sia_mst.sv]
// controller end: runs one register write or random read per command
// assumes software on a plain strobe port, sensor on sia_if
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "sia_consts.svh"
module sia_mst
#(
	parameter int LINE_NS = 10000
)
(
	input  wire logic        clk,
	input  wire logic        nrst,
	sia_if.mst               link,
	input  wire logic        vertical_sync_pin,
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [7:0]       rdata
);
	localparam int HOLD_NS  = `SIA_HOLD_LINES * LINE_NS;
	localparam int HOLD_CYC = (HOLD_NS + `SIA_CLK_NS - 1) / `SIA_CLK_NS;

	logic [1:0]              sda_s;
	logic [2:0]              vs_s;
	logic                    sda;
	logic                    slv_sel;
	logic [15:0]             reg_addr;
	logic [7:0]              wbyte;
	logic [7:0]              rbyte;
	logic [15:0]             hold_cnt;
	sia_pkg::sia_mst_st_t    st;
	sia_pkg::sia_step_t      step;
	logic [3:0]              ph;
	logic [3:0]              bi;
	logic [7:0]              sr;
	logic                    ack_ok;
	logic                    rd_op;
	logic                    busy;
	logic                    nack_err;
	logic                    refused;
	logic                    sleep_shadow;
	logic                    scl_oe_n;
	logic                    sda_oe_n;
	logic                    out_lvl;
	logic                    cmd_go;
	logic                    bad_cmd;
	logic                    rx_now;

	// registers that may only change while the sensor sleeps
	function automatic logic needs_sleep(input logic [15:0] a);
		return (a == `SIA_REG_LANE) || (a == `SIA_REG_ADBITS) || (a == `SIA_REG_ODBITS) ||
			(a == `SIA_REG_PORTS) || ((a >= `SIA_REG_INCK_A) && (a <= `SIA_REG_INCK_D));
	endfunction

	// byte sent in each step of a transaction
	function automatic logic [7:0] tx_of(input sia_pkg::sia_step_t s, input logic sel,
		input logic [15:0] ra, input logic [7:0] wb);
		logic [6:0] da;
		da = sel ? `SIA_ADDR_SEL1 : `SIA_ADDR_SEL0;
		case (s)
			sia_pkg::sia_s_adw:  return {da, 1'b0}; // RL3
			sia_pkg::sia_s_hi:   return ra[15:8]; // RL4
			sia_pkg::sia_s_lo:   return ra[7:0];
			sia_pkg::sia_s_data: return wb;
			sia_pkg::sia_s_adr:  return {da, 1'b1};
			default:             return 8'hFF;
		endcase
	endfunction

	// synchronisers for the data line and frame sync
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sda_s <= 2'h3;
			vs_s  <= 3'h7;
		end
		else
		begin
			sda_s <= {sda_s[0], link.sda};
			vs_s  <= {vs_s[1:0], vertical_sync_pin};
		end
	end
	assign sda = sda_s[1];

	// quiet window after each frame sync falling edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hold_cnt <= 16'h0000;
		else if (vs_s[2] & ~vs_s[1])
			hold_cnt <= 16'(HOLD_CYC); // RL14
		else if (hold_cnt != 16'h0000)
			hold_cnt <= hold_cnt - 16'h0001;
	end

	// software setup registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			slv_sel  <= 1'b0;
			reg_addr <= 16'h0000;
			wbyte    <= 8'h00;
		end
		else if (wr && !busy)
		begin
			case (addr)
				`SIA_CR_SLV:  slv_sel         <= wdata[0];
				`SIA_CR_RAH:  reg_addr[15:8]  <= wdata;
				`SIA_CR_RAL:  reg_addr[7:0]   <= wdata;
				`SIA_CR_WDAT: wbyte           <= wdata;
				default:      ;
			endcase
		end
	end

	// read port answers one cycle after the strobe only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata <= 8'h00;
		else if (rd)
		begin
			case (addr)
				`SIA_CR_SLV:  rdata <= {7'h00, slv_sel};
				`SIA_CR_RAH:  rdata <= reg_addr[15:8];
				`SIA_CR_RAL:  rdata <= reg_addr[7:0];
				`SIA_CR_WDAT: rdata <= wbyte;
				`SIA_CR_STAT: rdata <= {4'h0, sleep_shadow, refused, nack_err, busy};
				`SIA_CR_RDAT: rdata <= rbyte;
				default:      rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	assign cmd_go  = wr && (addr == `SIA_CR_CTRL) && wdata[`SIA_CTRL_GO] && !busy;
	assign bad_cmd = !sia_pkg::sia_in_map(reg_addr) || // RL18
		(!wdata[`SIA_CTRL_READ] && needs_sleep(reg_addr) && !sleep_shadow); // RL16
	assign rx_now  = (step == sia_pkg::sia_s_rd);

	// link engine: 16-cycle bit slot, clock low phases 0-5, high 6-15
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st           <= sia_pkg::sia_m_idle;
			step         <= sia_pkg::sia_s_adw;
			ph           <= 4'h0;
			bi           <= 4'h0;
			sr           <= 8'h00;
			ack_ok       <= 1'b0;
			rd_op        <= 1'b0;
			busy         <= 1'b0;
			nack_err     <= 1'b0;
			refused      <= 1'b0;
			sleep_shadow <= 1'b1;
			rbyte        <= 8'h00;
			scl_oe_n     <= 1'b1;
			sda_oe_n     <= 1'b1;
		end
		else
		begin
			ph <= (st == sia_pkg::sia_m_idle) ? 4'h0 : ph + 4'h1;
			case (st)
				sia_pkg::sia_m_idle:
				begin
					if (cmd_go)
					begin
						refused  <= bad_cmd;
						nack_err <= 1'b0;
						busy     <= !bad_cmd;
						rd_op    <= wdata[`SIA_CTRL_READ];
						if (!bad_cmd && !wdata[`SIA_CTRL_READ] && (reg_addr == `SIA_REG_SLEEP))
							sleep_shadow <= wbyte[0];
					end
					else if (busy && (hold_cnt == 16'h0000)) // RL14
					begin
						step <= sia_pkg::sia_s_adw;
						st   <= sia_pkg::sia_m_start;
					end
				end
				sia_pkg::sia_m_start:
				begin
					case (ph)
						`SIA_PH_SCL_LO:  scl_oe_n <= 1'b0;
						`SIA_PH_SDA:     sda_oe_n <= 1'b1;
						`SIA_PH_SCL_HI:  scl_oe_n <= 1'b1;
						`SIA_PH_SAMPLE:  sda_oe_n <= 1'b0; // RL5
						`SIA_PH_SCL_LO2: scl_oe_n <= 1'b0;
						`SIA_PH_LAST:
						begin
							bi <= 4'h0;
							sr <= tx_of(step, slv_sel, reg_addr, wbyte);
							st <= sia_pkg::sia_m_byte;
						end
						default: ;
					endcase
				end
				sia_pkg::sia_m_byte:
				begin
					case (ph)
						`SIA_PH_SCL_LO: scl_oe_n <= 1'b0;
						`SIA_PH_SDA:    sda_oe_n <= rx_now || (bi == `SIA_BYTE_BITS) || sr[7]; // RL1 RL7 RL13
						`SIA_PH_SCL_HI: scl_oe_n <= 1'b1;
						`SIA_PH_SAMPLE:
						begin
							if (bi == `SIA_BYTE_BITS)
								ack_ok <= ~sda;
							else if (rx_now)
								sr <= {sr[6:0], sda};
						end
						`SIA_PH_LAST:
						begin
							bi <= 4'h0;
							if (bi != `SIA_BYTE_BITS)
							begin
								bi <= bi + 4'h1;
								if (!rx_now)
									sr <= {sr[6:0], 1'b0};
							end
							else if (rx_now)
							begin
								rbyte <= sr;
								st    <= sia_pkg::sia_m_stop; // RL13
							end
							else if (!ack_ok)
							begin
								nack_err <= 1'b1;
								st       <= sia_pkg::sia_m_stop; // RL8
							end
							else
							begin
								case (step)
									sia_pkg::sia_s_adw, sia_pkg::sia_s_hi:
									begin
										step <= sia_pkg::sia_step_t'(step + 3'h1);
										sr   <= tx_of(sia_pkg::sia_step_t'(step + 3'h1), slv_sel, reg_addr, wbyte);
									end
									sia_pkg::sia_s_lo:
									begin
										if (rd_op)
										begin
											step <= sia_pkg::sia_s_adr;
											st   <= sia_pkg::sia_m_start; // RL11
										end
										else
										begin
											step <= sia_pkg::sia_s_data;
											sr   <= wbyte;
										end
									end
									sia_pkg::sia_s_adr:  step <= sia_pkg::sia_s_rd;
									default:             st   <= sia_pkg::sia_m_stop;
								endcase
							end
						end
						default: ;
					endcase
				end
				sia_pkg::sia_m_stop:
				begin
					case (ph)
						`SIA_PH_SCL_LO: scl_oe_n <= 1'b0;
						`SIA_PH_SDA:    sda_oe_n <= 1'b0;
						`SIA_PH_SCL_HI: scl_oe_n <= 1'b1;
						`SIA_PH_SAMPLE: sda_oe_n <= 1'b1;
						`SIA_PH_LAST:
						begin
							busy <= 1'b0;
							st   <= sia_pkg::sia_m_idle;
						end
						default: ;
					endcase
				end
				default: st <= sia_pkg::sia_m_idle;
			endcase
		end
	end

	// open-drain pins pull low only
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			out_lvl <= 1'b0;
		else
			out_lvl <= 1'b0;
	end
	assign link.m_scl_out  = out_lvl;
	assign link.m_sda_out  = out_lvl;
	assign link.m_scl_oe_n = scl_oe_n;
	assign link.m_sda_oe_n = sda_oe_n;
endmodule

// [include/sia_consts.svh]
// constants for the sensor two-wire register access block
// assumes a 40 MHz system clock and an open-drain two-wire link
//
// Summary of operation
// RL1: bytes go msb first, eight bits each
// RL2: respond to 0010000 or 0011010 per select
// RL3: address lsb zero writes, one reads
// RL4: two-byte register address, one-byte data
// RL5: data steady while clock high; start detected
// RL6: start without stop keeps the context
// RL7: receiver acks, transmitter releases data line
// RL8: master stops at once after a nack
// RL9: address bytes after write address load index
// RL10: index advances at each data ack bit
// RL11: random read: dummy write, restart, read
// RL12: bare read address returns byte at index
// RL13: master ack continues read; nack ends it
// RL14: no traffic for four lines after vsync
// RL15: frame registers apply at frame point
// RL16: immediate registers written only while sleeping; master refuses awake writes only to 3005, 300C, 3016, 301C, 3089-308C
// RL17: 4352 bytes in seventeen 256-byte pages
// RL18: master avoids addresses outside the map
// RL19: sleep bit resets to one, immediate
// RL20: idle-lane field picks 16, 8, 4 lanes
// RL21: freeze bit stops frame register updates
// RL22: master-run inhibit resets to one, immediate
// RL23: write data stored at index, then advance
`ifndef SIA_CONSTS_SVH
`define SIA_CONSTS_SVH

`define SIA_ADDR_SEL0   7'h10
`define SIA_ADDR_SEL1   7'h1A
`define SIA_REG_SLEEP   16'h3000
`define SIA_REG_LANE    16'h3005
`define SIA_REG_FREEZE  16'h3008
`define SIA_REG_RUN     16'h300A
`define SIA_REG_ADBITS  16'h300C
`define SIA_REG_ODBITS  16'h3016
`define SIA_REG_PORTS   16'h301C
`define SIA_REG_INCK_A  16'h3089
`define SIA_REG_INCK_D  16'h308C
`define SIA_PAGE_BASE   8'h30
`define SIA_PAGE_LAST   8'h40
`define SIA_MEM_BYTES   4352
`define SIA_SLEEP_RST   8'h01
`define SIA_LANE_RST    8'h00
`define SIA_FREEZE_RST  8'h00
`define SIA_RUN_RST     8'h01
`define SIA_BIT0_MASK   8'h01
`define SIA_LANE_MASK   8'hF0
`define SIA_LANES_16    4'h0
`define SIA_LANES_8     4'h1
`define SIA_LANES_4     4'h2
`define SIA_MASK_16     16'hFFFF
`define SIA_MASK_8      16'h00FF
`define SIA_MASK_4      16'h000F
`define SIA_SYNC_RST    4'hB
`define SIA_BYTE_BITS   4'h8
`define SIA_LAST_BIT    4'h7
`define SIA_PH_SCL_LO   4'h0
`define SIA_PH_SDA      4'h2
`define SIA_PH_SCL_HI   4'h6
`define SIA_PH_SAMPLE   4'hA
`define SIA_PH_SCL_LO2  4'hE
`define SIA_PH_LAST     4'hF
`define SIA_CLK_NS      25
`define SIA_HOLD_LINES  4
`define SIA_CR_CTRL     4'h0
`define SIA_CR_SLV      4'h1
`define SIA_CR_RAH      4'h2
`define SIA_CR_RAL      4'h3
`define SIA_CR_WDAT     4'h4
`define SIA_CR_STAT     4'h5
`define SIA_CR_RDAT     4'h6
`define SIA_CTRL_GO     0
`define SIA_CTRL_READ   1

`endif

// [include/sia_if.sv]
// two-wire link between the bus master and the sensor port
// resolves open-drain levels; idle lines read high (pull-up)
`timescale 1ns/1ps
interface sia_if;
	logic m_scl_out;
	logic m_scl_oe_n;
	logic m_sda_out;
	logic m_sda_oe_n;
	logic d_sda_out;
	logic d_sda_oe_n;
	logic scl;
	logic sda;

	// wired-and of every driver enabled low
	assign scl = m_scl_oe_n | m_scl_out;
	assign sda = (m_sda_oe_n | m_sda_out) & (d_sda_oe_n | d_sda_out);

	modport dev (input scl, input sda, output d_sda_out, output d_sda_oe_n);
	modport mst (input scl, input sda, output m_scl_out, output m_scl_oe_n, output m_sda_out, output m_sda_oe_n);
endinterface

// [include/sia_pkg.sv]
// types and shared decoding for the two-wire register access block
// assumes sia_consts.svh is on the include path
`include "sia_consts.svh"
package sia_pkg;
	typedef enum logic [5:0] {
		sia_d_idle = 6'b000001,
		sia_d_addr = 6'b000010,
		sia_d_ack  = 6'b000100,
		sia_d_recv = 6'b001000,
		sia_d_send = 6'b010000,
		sia_d_mack = 6'b100000
	} sia_dev_st_t;

	typedef enum logic [3:0] {
		sia_m_idle  = 4'b0001,
		sia_m_start = 4'b0010,
		sia_m_byte  = 4'b0100,
		sia_m_stop  = 4'b1000
	} sia_mst_st_t;

	typedef enum logic [2:0] {
		sia_s_adw  = 3'h0,
		sia_s_hi   = 3'h1,
		sia_s_lo   = 3'h2,
		sia_s_data = 3'h3,
		sia_s_adr  = 3'h4,
		sia_s_rd   = 3'h5
	} sia_step_t;

	// register address falls in one of the mapped pages
	function automatic logic sia_in_map(input logic [15:0] a);
		return (a[15:8] >= `SIA_PAGE_BASE) && (a[15:8] <= `SIA_PAGE_LAST);
	endfunction
endpackage

// [tb/sia_monitor.sv]
// wire-level checks on the two-wire link between master and sensor ends
// assumes the bench places it beside the interface, clk far above link rate
`timescale 1ns/1ps
module sia_monitor
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic m_scl_out,
	input wire logic m_scl_oe_n,
	input wire logic m_sda_out,
	input wire logic m_sda_oe_n,
	input wire logic d_sda_out,
	input wire logic d_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// open-drain outputs only ever pull low
	chk_outs_pull_low: assert property (!m_scl_out && !m_sda_out && !d_sda_out)
		else $error("link output driven high");
	// the clock wire follows the master alone
	chk_scl_from_master: assert property (scl == m_scl_oe_n)
		else $error("clock wire not from master");
	// low phase of a slot lasts six to eight cycles
	chk_scl_low_time: assert property ($fell(scl) |-> !scl[*6] ##[1:3] scl)
		else $error("clock low phase length off");
	// high phase holds at least eight cycles
	chk_scl_high_time: assert property ($rose(scl) |-> scl[*8])
		else $error("clock high phase too short");
	// start: data falls with clock high, clock holds four cycles
	chk_start_hold: assert property ($fell(sda) && scl |-> scl[*4] ##1 !scl)
		else $error("start condition shape off");
	// after a stop both lines stay released for eight cycles
	chk_stop_idle: assert property ($rose(sda) && scl |-> (sda && scl)[*8])
		else $error("lines not idle after stop");
	// device changes data only while clock is low
	chk_dev_sda_steady: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
		else $error("device moved data with clock high");
	// a device drive ends within a byte and an ack
	chk_dev_release: assert property ($fell(d_sda_oe_n) |-> ##[1:200] $rose(d_sda_oe_n))
		else $error("device never released data");

	// main link events
	cov_start: cover property ($fell(sda) && scl);
	cov_stop: cover property ($rose(sda) && scl);
	cov_dev_ack: cover property ($fell(d_sda_oe_n));
endmodule

// [tb/tb_sia.sv]
// bench joining both ends of the two-wire register port
// assumes interface and design modules compiled before it
`timescale 1ns/1ps
module tb_sia;
	logic        clk = 1'b0;
	logic        nrst = 1'b1;
	logic        v = 1'b1;
	logic        sel = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        slv = 1'b0;
	logic [7:0]  rdata;
	logic        slp;
	logic [15:0] lanes;
	logic        frz;
	logic        run;
	logic        refl;
	logic [7:0]  st;
	logic [7:0]  q;
	logic        sda_d = 1'b1;
	logic [15:0] masks [4] = '{16'h00FF, 16'h000F, 16'hFFFF, 16'hFFFF};
	int          fail_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          pulses = 0;
	int          t_start = 0;
	int          tv = 0;

	sia_if lk();
	sia_dev sia_dev_i(.clk(clk), .nrst(nrst), .link(lk.dev), .address_select_setting(sel),
		.vertical_sync_pin(v), .sleep_mode(slp), .lanes_active(lanes), .update_freeze_bit(frz),
		.master_run_inhibit(run), .reflect_pulse(refl));
	sia_mst #(.LINE_NS(1000)) sia_mst_i(.clk(clk), .nrst(nrst), .link(lk.mst), .vertical_sync_pin(v),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	sia_monitor sia_monitor_i(.clk(clk), .nrst(nrst), .m_scl_out(lk.m_scl_out), .m_scl_oe_n(lk.m_scl_oe_n),
		.m_sda_out(lk.m_sda_out), .m_sda_oe_n(lk.m_sda_oe_n), .d_sda_out(lk.d_sda_out),
		.d_sda_oe_n(lk.d_sda_oe_n), .scl(lk.scl), .sda(lk.sda));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// cycle count, take strobes, start times, hang limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		sda_d <= lk.sda;
		if (refl === 1'b1)
			pulses <= pulses + 1;
		if (sda_d && !lk.sda && lk.scl)
			t_start <= cyc;
		if (cyc == 60000)
		begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle register strobes
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic get(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask

	// one link command, polled to completion; read data lands in q
	task automatic xfer(input logic [15:0] ra, input logic [7:0] d, input logic r);
		int n;
		put(4'h1, {7'h00, slv});
		put(4'h2, ra[15:8]);
		put(4'h3, ra[7:0]);
		put(4'h4, d);
		put(4'h0, {6'h00, r, 1'b1});
		n = 0;
		st = 8'h01;
		while (st[0] !== 1'b0 && n < 3000)
		begin
			get(4'h5);
			st = q;
			n++;
		end
		chk(16'(st[0]), 16'h0000);
		if (r)
			get(4'h6);
	endtask

	// main sequence
	initial
	begin
		// a real falling edge so the asynchronous resets fire
		nrst <= 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk(16'(slp), 16'h0001);
		chk(lanes, 16'hFFFF);
		chk(16'(frz), 16'h0000);
		chk(16'(run), 16'h0001);
		xfer(16'h3000, 8'h00, 1'b1);
		chk(16'(q), 16'h0001);
		xfer(16'h300A, 8'h00, 1'b1);
		chk(16'(q), 16'h0001);
		$display("reset values done");
		for (int i = 0; i < 4; i++)
		begin
			xfer(16'h3005, {4'((i + 1) % 4), 4'h0}, 1'b0);
			chk(lanes, masks[i]);
			xfer(16'h3005, 8'h00, 1'b1);
			chk(16'(q), {8'h00, 4'((i + 1) % 4), 4'h0});
		end
		$display("lane codes done");
		xfer(16'h3008, 8'hFF, 1'b0);
		chk(16'(frz), 16'h0001);
		xfer(16'h3008, 8'h00, 1'b1);
		chk(16'(q), 16'h0001);
		v <= 1'b0;
		tv = cyc;
		repeat (8) @(posedge clk);
		chk(16'(pulses), 16'h0000);
		xfer(16'h3008, 8'h00, 1'b0);
		chk(16'(t_start - tv >= 160), 16'h0001);
		v <= 1'b1;
		repeat (8) @(posedge clk);
		v <= 1'b0;
		repeat (8) @(posedge clk);
		chk(16'(pulses), 16'h0001);
		v <= 1'b1;
		$display("freeze and sync done");
		slv = 1'b1;
		xfer(16'h3100, 8'hA5, 1'b0);
		chk(16'(st[1]), 16'h0001);
		sel <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(16'h3100, 8'hA5, 1'b0);
		chk(16'(st[1]), 16'h0000);
		xfer(16'h40FF, 8'h5A, 1'b0);
		xfer(16'h3100, 8'h00, 1'b1);
		chk(16'(q), 16'h00A5);
		xfer(16'h40FF, 8'h00, 1'b1);
		chk(16'(q), 16'h005A);
		$display("address select done");
		xfer(16'h4100, 8'h11, 1'b0);
		chk(16'(st[2]), 16'h0001);
		xfer(16'h3000, 8'h00, 1'b0);
		chk(16'(slp), 16'h0000);
		xfer(16'h3005, 8'h10, 1'b0);
		chk(16'(st[2]), 16'h0001);
		chk(lanes, 16'hFFFF);
		xfer(16'h300A, 8'h00, 1'b0);
		chk(16'(run), 16'h0000);
		$display("refusals done");
		finish_test();
	end
endmodule
